// file: rtl/rpc_consts.svh
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// register byte offsets
`define RPC_OFS_CFG 8'h00
`define RPC_OFS_AA 8'h04
`define RPC_OFS_CRCLEN 8'h08
`define RPC_OFS_CTRL 8'h0C
`define RPC_OFS_STAT 8'h10
`define RPC_OFS_FLAGS 8'h14
`define RPC_OFS_DATA 8'h18

// field positions
`define RPC_TXE_LSB 24
`define RPC_DEC_EN_BIT 29
`define RPC_OVR_EN_BIT 30
`define RPC_DBG_BIT 31
`define RPC_SEED_MSB 23
`define RPC_MAXLEN_LSB 24
`define RPC_CTRL_SEEDSEL 0
`define RPC_CTRL_ADV 1
`define RPC_CTRL_CIPHER 2

// event vector layout
`define RPC_EV_W 10
`define RPC_EV_DEC 5
`define RPC_EV_OVR 6
`define RPC_EV_LEN 7
`define RPC_EV_OK 8
`define RPC_EV_CRC 9

// reset values and counts
`define RPC_RST_WORD 32'h0000_0000
`define RPC_RST_CTRL 6'h00
`define RPC_RST_EV 10'h000
`define RPC_CRC_BYTES 3
`define RPC_ADV_SEED 24'h555555

`endif

// file: rtl/rpc_pkg.sv
package rpc_pkg;

    // demodulator side of one received frame
    typedef struct packed {
        logic sync;
        logic [31:0] aa;
        logic hdr;
        logic [7:0] len;
        logic bvalid;
        logic [7:0] data;
        logic done;
        logic crc_ok;
        logic [23:0] crc;
        logic mic_ok;
    } rpc_rx_t;

    // modulator side: frame start and fault sources
    typedef struct packed {
        logic start;
        logic [4:0] fault;
    } rpc_tx_t;

    // fields handed to the modulator per frame
    typedef struct packed {
        logic adv;
        logic [31:0] aa;
        logic [23:0] seed;
    } rpc_txcfg_t;

    typedef enum logic [1:0] {
        RPC_IDLE = 2'b00,
        RPC_PAY = 2'b01,
        RPC_CRC = 2'b11
    } rpc_state_t;

endpackage

// file: rtl/rpc_top.sv
// Function
// - a transmit fault latches its flag and interrupt only when its enable is set
// - raw status always shows every transmit fault, unmasked
// - one enable gates the decrypt fault flag and interrupt
// - decrypt fault when integrity code mismatches, cipher on, address matched, length nonzero
// - decrypt fault decision ignores the checksum result
// - one enable gates the receive overrun fault interrupt
// - debug bit set stores received checksum after payload, else payload only
// - stored checksum keeps packet byte order; software reverses it
// - debug bit set accepts every packet, success flag set, no checksum error
// - transmit inserts the 32-bit access address right after the preamble
// - receive accepts only frames whose access address matches
// - packet class comes only from the advertising select flag
// - configured seed initialises the checksum for data and sync packets
// - configured seed is ignored while the seed select flag is 0
// - length above maximum truncates stored payload and, with debug bit clear, ends with checksum error
// - length overrun raises its event in status and, if enabled, in flags
// - length at or below maximum is processed normally
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.svh"

module rpc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fill side
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    // drain side
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // handshake terms
    wire logic push = s_valid && s_ready;
    wire logic pop = m_valid && m_ready;
    assign s_ready = count != CW'(DEPTH);
    assign m_valid = count != '0;
    assign m_data = mem[rd_ptr];

    // storage write
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr] <= s_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? step(wr_ptr) : wr_ptr;
            rd_ptr <= pop ? step(rd_ptr) : rd_ptr;
            count <= count + CW'(push) - CW'(pop);
        end
    end
endmodule

module rpc_top #(
    parameter int FIFO_DEPTH = 4,
    parameter logic [23:0] ADV_SEED = `RPC_ADV_SEED
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // radio side
    input wire rpc_pkg::rpc_rx_t rx,
    input wire rpc_pkg::rpc_tx_t tx,
    output rpc_pkg::rpc_txcfg_t tx_cfg,
    // status outputs
    output logic irq,
    output logic rx_active
);
    logic [7:0] cfg_hi;
    logic [31:0] aa;
    logic [31:0] crclen;
    logic [5:0] ctrl;
    logic [`RPC_EV_W-1:0] stat;
    logic [`RPC_EV_W-1:0] flags;
    rpc_pkg::rpc_state_t state;
    rpc_pkg::rpc_state_t next_state;
    logic [7:0] cnt;
    logic [7:0] lim;
    logic [7:0] hdr_len;
    logic overrun;
    logic [23:0] crc_sh;
    logic [1:0] crc_idx;
    logic push_ready;
    logic pop_valid;
    logic [7:0] pop_data;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // apb decode
    wire logic acc = psel && penable && !pready;
    wire logic fire = psel && penable && pready;
    wire logic wr_fire = fire && pwrite;
    wire logic sel_cfg = hit(paddr, `RPC_OFS_CFG);
    wire logic sel_aa = hit(paddr, `RPC_OFS_AA);
    wire logic sel_crcl = hit(paddr, `RPC_OFS_CRCLEN);
    wire logic sel_ctrl = hit(paddr, `RPC_OFS_CTRL);
    wire logic sel_stat = hit(paddr, `RPC_OFS_STAT);
    wire logic sel_flags = hit(paddr, `RPC_OFS_FLAGS);
    wire logic sel_data = hit(paddr, `RPC_OFS_DATA);
    wire logic sel_any = sel_cfg | sel_aa | sel_crcl | sel_ctrl | sel_stat | sel_flags | sel_data;
    // pop only the byte that this read reported as valid in its answer
    wire logic pop = fire && !pwrite && sel_data && prdata[8];

    // configuration fields
    wire logic [4:0] txen = cfg_hi[4:0];
    wire logic dec_en = cfg_hi[`RPC_DEC_EN_BIT-`RPC_TXE_LSB];
    wire logic ovr_en = cfg_hi[`RPC_OVR_EN_BIT-`RPC_TXE_LSB];
    wire logic dbg = cfg_hi[`RPC_DBG_BIT-`RPC_TXE_LSB];
    wire logic [23:0] seed = crclen[`RPC_SEED_MSB:0];
    wire logic [7:0] max_len = crclen[31:`RPC_MAXLEN_LSB];
    wire logic seed_sel = ctrl[`RPC_CTRL_SEEDSEL];
    wire logic cipher = ctrl[`RPC_CTRL_CIPHER];

    // empty buffer reads a zero byte, never stale or unwritten storage
    wire logic [7:0] head_byte = pop_valid ? pop_data : 8'h00;

    // read mux, unused bits read zero
    wire logic [31:0] rd_word =
        sel_cfg ? {cfg_hi, 24'h000000} :
        sel_aa ? aa :
        sel_crcl ? crclen :
        sel_ctrl ? {26'h0000000, ctrl} :
        sel_stat ? {22'h000000, stat} :
        sel_flags ? {22'h000000, flags} :
        sel_data ? {23'h000000, pop_valid, head_byte} : 32'h00000000;

    // receive datapath terms
    wire logic in_pay = state == rpc_pkg::RPC_PAY;
    wire logic in_crc = state == rpc_pkg::RPC_CRC;
    wire logic aa_hit = rx.sync && rx.aa == aa;
    wire logic len_over = rx.len > max_len;
    wire logic room = cnt < lim;
    wire logic pay_push = in_pay && rx.bvalid && room;
    wire logic push_valid = pay_push || in_crc;
    wire logic [7:0] push_data = in_crc ? crc_sh[7:0] : rx.data;
    wire logic end_pkt = in_pay && rx.done;
    wire logic crc_push = in_crc && push_ready;

    // events of this cycle
    wire logic dec_ev = end_pkt && cipher && hdr_len != 8'h00 && !rx.mic_ok;
    wire logic ovr_ev = pay_push && !push_ready;
    wire logic len_ev = in_pay && rx.hdr && len_over;
    wire logic ok_ev = end_pkt && (dbg || (rx.crc_ok && !overrun));
    wire logic crc_ev = end_pkt && !dbg && (!rx.crc_ok || overrun);
    wire logic [`RPC_EV_W-1:0] ev = {crc_ev, ok_ev, len_ev, ovr_ev, dec_ev, tx.fault};
    wire logic [`RPC_EV_W-1:0] ev_mask = {ctrl[5:3], ovr_en, dec_en, txen};

    // write-one-to-clear, a new event wins over the clear
    wire logic [`RPC_EV_W-1:0] stat_clr = (wr_fire && sel_stat) ? pwdata[`RPC_EV_W-1:0] : `RPC_RST_EV;
    wire logic [`RPC_EV_W-1:0] flag_clr = (wr_fire && sel_flags) ? pwdata[`RPC_EV_W-1:0] : `RPC_RST_EV;
    wire logic [`RPC_EV_W-1:0] next_stat = (stat & ~stat_clr) | ev;
    wire logic [`RPC_EV_W-1:0] next_flags = (flags & ~flag_clr) | (ev & ev_mask);

    // apb answer after one wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= `RPC_RST_WORD;
            pslverr <= 1'b0;
        end else begin
            pready <= acc;
            prdata <= acc ? rd_word : prdata;
            pslverr <= acc && !sel_any;
        end
    end

    // configuration words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_hi <= 8'h00;
            aa <= `RPC_RST_WORD;
            crclen <= `RPC_RST_WORD;
            ctrl <= `RPC_RST_CTRL;
        end else if (wr_fire) begin
            cfg_hi <= sel_cfg ? pwdata[31:24] : cfg_hi;
            aa <= sel_aa ? pwdata : aa;
            crclen <= sel_crcl ? pwdata : crclen;
            ctrl <= sel_ctrl ? pwdata[5:0] : ctrl;
        end
    end

    // sticky status and gated flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat <= `RPC_RST_EV;
            flags <= `RPC_RST_EV;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            flags <= next_flags;
            irq <= |next_flags;
        end
    end

    // receive sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            rpc_pkg::RPC_IDLE: begin
                if (aa_hit) begin
                    next_state = rpc_pkg::RPC_PAY;
                end
            end
            rpc_pkg::RPC_PAY: begin
                if (rx.done) begin
                    next_state = dbg ? rpc_pkg::RPC_CRC : rpc_pkg::RPC_IDLE;
                end
            end
            rpc_pkg::RPC_CRC: begin
                if (crc_push && crc_idx == 2'(`RPC_CRC_BYTES - 1)) begin
                    next_state = rpc_pkg::RPC_IDLE;
                end
            end
            default: begin
                next_state = rpc_pkg::RPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rpc_pkg::RPC_IDLE;
            rx_active <= 1'b0;
        end else begin
            state <= next_state;
            rx_active <= next_state != rpc_pkg::RPC_IDLE;
        end
    end

    // payload count and truncation limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
            lim <= 8'h00;
            hdr_len <= 8'h00;
            overrun <= 1'b0;
        end else if (state == rpc_pkg::RPC_IDLE) begin
            cnt <= 8'h00;
            lim <= max_len;
            hdr_len <= 8'h00;
            overrun <= 1'b0;
        end else if (in_pay) begin
            cnt <= pay_push ? cnt + 8'h01 : cnt;
            lim <= rx.hdr ? (len_over ? max_len : rx.len) : lim;
            hdr_len <= rx.hdr ? rx.len : hdr_len;
            overrun <= overrun | len_ev;
        end
    end

    // checksum bytes appended low byte first, as on air
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_sh <= 24'h000000;
            crc_idx <= 2'h0;
        end else if (end_pkt) begin
            crc_sh <= rx.crc;
            crc_idx <= 2'h0;
        end else if (crc_push) begin
            crc_sh <= {8'h00, crc_sh[23:8]};
            crc_idx <= crc_idx + 2'h1;
        end
    end

    // transmit fields snapshot at frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cfg <= '0;
        end else if (tx.start) begin
            tx_cfg.aa <= aa;
            tx_cfg.adv <= ctrl[`RPC_CTRL_ADV];
            tx_cfg.seed <= seed_sel ? seed : ADV_SEED;
        end
    end

    // payload buffer toward software
    rpc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .s_valid(push_valid),
        .s_ready(push_ready),
        .s_data(push_data),
        .m_valid(pop_valid),
        .m_ready(pop),
        .m_data(pop_data)
    );

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence dbg_end;
        in_pay && rx.done && dbg;
    endsequence

    sequence crc_drain;
        in_crc && push_valid && crc_idx == 2'h0;
    endsequence

    tx_mask_a: assert property (((flags[4:0] & ~$past(flags[4:0])) & ~$past(txen)) == 5'h00)
        else $error("masked transmit fault latched");
    tx_raw_a: assert property (|tx.fault |=> (stat[4:0] & $past(tx.fault)) == $past(tx.fault))
        else $error("transmit fault missing from status");
    dec_gate_a: assert property (dec_ev && !flags[`RPC_EV_DEC] |=> flags[`RPC_EV_DEC] == $past(dec_en))
        else $error("decrypt flag gating wrong");
    dec_cause_a: assert property (end_pkt && cipher && hdr_len != 8'h00 && !rx.mic_ok |=> stat[`RPC_EV_DEC])
        else $error("decrypt fault not reported");
    ovr_gate_a: assert property (ovr_ev && ovr_en |=> flags[`RPC_EV_OVR] && irq)
        else $error("overrun interrupt not raised");
    dbg_seq_a: assert property (dbg_end |=> crc_drain ##0 !in_pay)
        else $error("checksum bytes not appended");
    dbg_ok_a: assert property (dbg_end |=> stat[`RPC_EV_OK] && !(stat[`RPC_EV_CRC] && !$past(stat[`RPC_EV_CRC])))
        else $error("debug mode did not accept packet");
    aa_match_a: assert property (state == rpc_pkg::RPC_IDLE && rx.sync && rx.aa != aa |=> state == rpc_pkg::RPC_IDLE)
        else $error("foreign access address accepted");
    seed_sel_a: assert property (tx.start && !seed_sel |=> tx_cfg.seed == ADV_SEED)
        else $error("seed used while not selected");
    trunc_a: assert property (in_pay && !room |-> !push_valid)
        else $error("payload stored past limit");
    len_ev_a: assert property (in_pay && rx.hdr && rx.len > max_len |=> stat[`RPC_EV_LEN])
        else $error("length overrun not reported");
    len_ok_a: assert property (in_pay && rx.hdr && rx.len <= max_len |=> lim == $past(rx.len) && !overrun)
        else $error("length error on legal length");
endmodule

`default_nettype wire

// file: tb/rpc_peer.sv
`timescale 1ns/1ps
`default_nettype none

module rpc_peer (
    // clock
    input wire logic pclk,
    // demodulator side seen by the block
    output var rpc_pkg::rpc_rx_t rx
);
    // quiet link at time zero
    initial begin
        rx = '0;
    end

    // one received frame: sync, header, bytes, end; gap idles after each byte
    task automatic frame(input logic [31:0] aa, input logic [7:0] len, input int nb, input logic [23:0] crc,
                         input logic crc_ok, input logic mic_ok, input int gap);
        int i;
        int g;
        @(posedge pclk);
        rx.sync <= 1'b1;
        rx.aa <= aa;
        @(posedge pclk);
        rx.sync <= 1'b0;
        rx.aa <= ~aa;
        rx.hdr <= 1'b1;
        rx.len <= len;
        for (i = 0; i < nb; i++) begin
            @(posedge pclk);
            rx.hdr <= 1'b0;
            rx.len <= ~len;
            rx.bvalid <= 1'b1;
            rx.data <= 8'hA0 + 8'(i);
            for (g = 0; g < gap; g++) begin
                @(posedge pclk);
                rx.bvalid <= 1'b0;
                rx.data <= ~rx.data;
            end
        end
        @(posedge pclk);
        rx.hdr <= 1'b0;
        rx.bvalid <= 1'b0;
        rx.data <= ~rx.data;
        rx.done <= 1'b1;
        rx.crc <= crc;
        rx.crc_ok <= crc_ok;
        rx.mic_ok <= mic_ok;
        @(posedge pclk);
        rx.done <= 1'b0;
        rx.crc <= ~crc;
        rx.crc_ok <= ~crc_ok;
        rx.mic_ok <= ~mic_ok;
    endtask
endmodule

`default_nettype wire

// file: tb/tb_radio_packet_rx_tx_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.svh"

module tb_radio_packet_rx_tx_config;
    localparam logic [23:0] ADV_SEED = 24'h5A5A5A;
    logic pclk;
    logic presetn;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rpc_pkg::rpc_rx_t rx;
    rpc_pkg::rpc_tx_t tx;
    rpc_pkg::rpc_txcfg_t tx_cfg;
    logic irq;
    logic rx_active;
    logic [31:0] rd_q;
    logic rd_err;
    logic [31:0] dbg_exp [4];
    int error_cnt;
    int total_checks;
    int i;

    rpc_top #(.FIFO_DEPTH(4), .ADV_SEED(ADV_SEED)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx(rx), .tx(tx), .tx_cfg(tx_cfg), .irq(irq), .rx_active(rx_active));
    rpc_peer peer_u (.pclk(pclk), .rx(rx));

    // clock
    always #50 pclk = ~pclk;

    // one apb transfer, held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_q = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // clear sticky events and empty the buffer
    task automatic clean();
        int n;
        apb(`RPC_OFS_STAT, 1'b1, 32'h3FF);
        apb(`RPC_OFS_FLAGS, 1'b1, 32'h3FF);
        for (n = 0; n < 8; n++) begin
            apb(`RPC_OFS_DATA, 1'b0, 32'h0);
        end
    endtask

    task automatic txgo();
        @(posedge pclk);
        tx.start <= 1'b1;
        @(posedge pclk);
        tx.start <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        wrap_up();
    end

    // tests
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {paddr, psel, penable, pwrite, pwdata} = '0;
        tx = '0;
        error_cnt = 0;
        total_checks = 0;
        dbg_exp = '{32'h1A0, 32'h111, 32'h122, 32'h133};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and unmapped access
        apb(`RPC_OFS_CFG, 1'b0, 32'h0);
        chk("cfg_rst", rd_q, `RPC_RST_WORD);
        apb(`RPC_OFS_AA, 1'b0, 32'h0);
        chk("aa_rst", rd_q, `RPC_RST_WORD);
        apb(`RPC_OFS_CRCLEN, 1'b0, 32'h0);
        chk("crclen_rst", rd_q, `RPC_RST_WORD);
        apb(8'h1C, 1'b1, 32'hFFFF_FFFF);
        apb(8'h1C, 1'b0, 32'h0);
        chk("unmapped_err", 32'(rd_err), 32'h1);
        chk("unmapped_data", rd_q, 32'h0);
        $display("test regs done");
        // transmit config: address, class, seed selection
        apb(`RPC_OFS_AA, 1'b1, 32'h8E89BED6);
        apb(`RPC_OFS_CRCLEN, 1'b1, 32'h02ABCDEF);
        apb(`RPC_OFS_CRCLEN, 1'b0, 32'h0);
        chk("crclen_rw", rd_q, 32'h02ABCDEF);
        apb(`RPC_OFS_CTRL, 1'b1, 32'h0);
        txgo();
        chk("tx_aa", tx_cfg.aa, 32'h8E89BED6);
        chk("tx_adv0", 32'(tx_cfg.adv), 32'h0);
        chk("tx_seed_off", 32'(tx_cfg.seed), 32'(ADV_SEED));
        apb(`RPC_OFS_CTRL, 1'b1, 32'h3);
        txgo();
        chk("tx_adv1", 32'(tx_cfg.adv), 32'h1);
        chk("tx_seed_on", 32'(tx_cfg.seed), 32'hABCDEF);
        $display("test tx_cfg done");
        // transmit faults: raw unmasked, flags and irq gated
        apb(`RPC_OFS_CFG, 1'b1, 32'h0500_0000);
        @(posedge pclk);
        tx.fault <= 5'h1F;
        @(posedge pclk);
        tx.fault <= 5'h00;
        repeat (2) @(posedge pclk);
        chk("irq_set", 32'(irq), 32'h1);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("tx_raw", 32'(rd_q[4:0]), 32'h1F);
        apb(`RPC_OFS_FLAGS, 1'b0, 32'h0);
        chk("tx_flags", 32'(rd_q[4:0]), 32'h05);
        clean();
        chk("irq_clr", 32'(irq), 32'h0);
        $display("test tx_fault done");
        // good frame, slow peer, then a frame with a foreign address
        apb(`RPC_OFS_CTRL, 1'b1, 32'h8);
        peer_u.frame(32'h8E89BED6, 8'd2, 2, 24'h0, 1'b1, 1'b1, 2);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("ok_stat", rd_q & 32'h380, 32'h100);
        for (i = 0; i < 3; i++) begin
            apb(`RPC_OFS_DATA, 1'b0, 32'h0);
            chk("ok_byte", rd_q, (i < 2) ? 32'h1A0 + i : 32'h0);
        end
        clean();
        peer_u.frame(32'h8E89BED7, 8'd2, 2, 24'h0, 1'b1, 1'b1, 0);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("foreign_stat", rd_q, 32'h0);
        apb(`RPC_OFS_DATA, 1'b0, 32'h0);
        chk("foreign_data", rd_q, 32'h0);
        chk("foreign_idle", 32'(rx_active), 32'h0);
        $display("test rx done");
        // length overrun: truncated store, checksum error, gated flag
        peer_u.frame(32'h8E89BED6, 8'd4, 4, 24'h0, 1'b1, 1'b1, 0);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("len_stat", rd_q & 32'h280, 32'h280);
        apb(`RPC_OFS_FLAGS, 1'b0, 32'h0);
        chk("len_flag", rd_q & 32'h80, 32'h80);
        for (i = 0; i < 3; i++) begin
            apb(`RPC_OFS_DATA, 1'b0, 32'h0);
            chk("len_byte", rd_q, (i < 2) ? 32'h1A0 + i : 32'h0);
        end
        clean();
        $display("test overrun done");
        // checksum debug: bad checksum accepted, crc stored after payload
        apb(`RPC_OFS_CRCLEN, 1'b1, 32'h08ABCDEF);
        apb(`RPC_OFS_CFG, 1'b1, 32'h8000_0000);
        peer_u.frame(32'h8E89BED6, 8'd1, 1, 24'h332211, 1'b0, 1'b1, 0);
        @(negedge pclk);
        chk("dbg_active", 32'(rx_active), 32'h1);
        repeat (4) @(posedge pclk);
        chk("dbg_idle", 32'(rx_active), 32'h0);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("dbg_stat", rd_q & 32'h300, 32'h100);
        for (i = 0; i < 5; i++) begin
            apb(`RPC_OFS_DATA, 1'b0, 32'h0);
            chk("dbg_byte", rd_q, (i < 4) ? dbg_exp[i] : 32'h0);
        end
        clean();
        $display("test debug done");
        // decrypt fault with bad checksum, enabled then disabled
        apb(`RPC_OFS_CTRL, 1'b1, 32'h4);
        for (i = 0; i < 2; i++) begin
            apb(`RPC_OFS_CFG, 1'b1, (i == 0) ? 32'h2000_0000 : 32'h0);
            peer_u.frame(32'h8E89BED6, 8'd1, 1, 24'h0, 1'b0, 1'b0, 0);
            apb(`RPC_OFS_STAT, 1'b0, 32'h0);
            chk("dec_stat", rd_q & 32'h20, 32'h20);
            apb(`RPC_OFS_FLAGS, 1'b0, 32'h0);
            chk("dec_flag", rd_q & 32'h20, (i == 0) ? 32'h20 : 32'h0);
            clean();
        end
        // zero length frame never raises a decrypt fault
        peer_u.frame(32'h8E89BED6, 8'd0, 0, 24'h0, 1'b1, 1'b0, 0);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("dec_len0", rd_q & 32'h20, 32'h0);
        clean();
        $display("test decrypt done");
        // buffer overflow: peer floods, bench drains late
        apb(`RPC_OFS_CFG, 1'b1, 32'h4000_0000);
        peer_u.frame(32'h8E89BED6, 8'd6, 6, 24'h0, 1'b1, 1'b1, 0);
        apb(`RPC_OFS_STAT, 1'b0, 32'h0);
        chk("ovr_stat", rd_q & 32'h40, 32'h40);
        apb(`RPC_OFS_FLAGS, 1'b0, 32'h0);
        chk("ovr_flag", rd_q & 32'h40, 32'h40);
        for (i = 0; i < 5; i++) begin
            apb(`RPC_OFS_DATA, 1'b0, 32'h0);
            chk("ovr_byte", rd_q, (i < 4) ? 32'h1A0 + i : 32'h0);
        end
        $display("test overflow done");
        wrap_up();
    end
endmodule

`default_nettype wire
